//--- hw/ctsf_pkg.sv
// Package: register map, field layouts and types of the timestamp/FIFO bank
package ctsf_pkg;

  // Register byte addresses
  localparam logic [7:0] OFS_TX_MPEG = 8'h00dc;
  localparam logic [7:0] OFS_TX_SAT  = 8'h00e0;
  localparam logic [7:0] OFS_RX_MPEG = 8'h00e4;
  localparam logic [7:0] OFS_RX_SAT  = 8'h00e8;
  localparam logic [7:0] OFS_APP_CTL = 8'h00ec;

  // Reset values
  localparam logic [31:0] RST_OFFSET  = 32'h0000_0000;
  localparam logic [31:0] RST_APP_CTL = 32'h0000_0000;

  // Field positions inside the application data control register
  localparam int BIT_ISO_RX      = 0;
  localparam int BIT_ISO_TX      = 1;
  localparam int BIT_ASYNC_RX    = 2;
  localparam int BIT_ASYNC_TX    = 3;
  localparam int BIT_CAPTURE_ALL = 15;

  // Cycle timer moduli: sub-cycle wraps at 3072, cycle count at 8000
  localparam logic [12:0] SUB_CYCLE_MOD = 13'h0c00;
  localparam logic [13:0] CYCLE_CNT_MOD = 14'h1f40;

  // Timer or offset word; packed from bit 31 down to bit 0
  typedef struct packed {
    logic [11:0] sub_cycle_field;
    logic [12:0] cycle_count_field;
    logic [6:0]  seconds_offset_field;
  } ctsf_ts_t;

  // Register port request
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } ctsf_bus_req_t;

  // FIFO path control bits
  typedef struct packed {
    logic iso_capture_all;
    logic async_tx_fifo_en;
    logic async_rx_fifo_en;
    logic iso_tx_fifo_en;
    logic iso_rx_fifo_en;
  } ctsf_ctl_t;

  // Receive hold states
  typedef enum logic [1:0] {
    RX_IDLE = 2'b01,
    RX_HOLD = 2'b10
  } ctsf_rx_st_t;

endpackage

//--- hw/ctsf_regs.sv
// Timestamp offset registers, cell stamping, receive hold and FIFO control
`timescale 1ns/1ps

// Behaviour
// - Outgoing MPEG cell stamp is sampled cycle timer plus transmit offset.
// - Outgoing satellite cell stamp is sampled cycle timer plus transmit offset.
// - Received MPEG cell release time is its stamp plus receive offset.
// - Received satellite cell release time is its stamp plus receive offset.
// - Both transmit offset addresses reach one shared register.
// - Both receive offset addresses reach one shared register.
// - Bits 0 to 6 are read/write, added to the timer seconds.
// - Bits 7 to 19 are read/write cycle count offset, at most 7999.
// - Bits 20 to 31 are read/write sub-cycle offset, at most 3071.
// - All offset registers read zero after power-up or software reset.
// - Isochronous receive FIFO accepts data only while control bit 0 is set.
// - Isochronous transmit FIFO sends only while control bit 1 is set.
// - Asynchronous receive FIFO accepts data only while control bit 2 is set.
// - Asynchronous transmit FIFO sends only while control bit 3 is set.
// - A serial bus reset clears the asynchronous transmit enable.
// - Control bit 15 captures every isochronous packet regardless of channel.
// - Control register reads zero after reset; bits 4 to 14 unused.
module ctsf_regs #(
  parameter int DATA_W = 32
) (
  input  wire logic                   ref_clk,
  input  wire logic                   arst_n,
  input  wire logic                   soft_rst,
  input  wire logic                   link_bus_reset,
  input  wire ctsf_pkg::ctsf_bus_req_t bus_req,
  output logic [31:0]                 bus_rdata,
  input  wire ctsf_pkg::ctsf_ts_t     cycle_timer_reg,
  input  wire logic                   tx_cell_req,
  input  wire logic                   tx_cell_sat,
  output logic                        tx_stamp_valid,
  output logic                        tx_stamp_sat,
  output ctsf_pkg::ctsf_ts_t          tx_stamp,
  input  wire logic                   rx_cell_valid,
  output logic                        rx_cell_ready,
  input  wire logic                   rx_cell_sat,
  input  wire ctsf_pkg::ctsf_ts_t     rx_cell_stamp,
  input  wire logic [DATA_W-1:0]      rx_cell_data,
  output logic                        rx_app_valid,
  output logic                        rx_app_sat,
  output logic [DATA_W-1:0]           rx_app_data,
  input  wire logic                   iso_pkt_valid,
  input  wire logic                   iso_chan_match,
  output logic                        iso_rx_accept,
  input  wire logic                   iso_tx_pending,
  output logic                        iso_tx_send,
  input  wire logic                   async_pkt_valid,
  output logic                        async_rx_accept,
  input  wire logic                   async_tx_pending,
  output logic                        async_tx_send,
  output ctsf_pkg::ctsf_ctl_t         fifo_ctl
);

  // Refuse a cell width the datapath cannot carry
  if (DATA_W < 1) begin : g_bad_width
    $error("DATA_W must be at least 1");
  end

  // Whole state of the block
  typedef struct packed {
    ctsf_pkg::ctsf_ts_t   tx_off;
    ctsf_pkg::ctsf_ts_t   rx_off;
    ctsf_pkg::ctsf_ctl_t  ctl;
    logic [31:0]          rdata;
    ctsf_pkg::ctsf_ts_t   tx_stamp;
    logic                 tx_valid;
    logic                 tx_sat;
    ctsf_pkg::ctsf_rx_st_t rx_st;
    ctsf_pkg::ctsf_ts_t   rx_release;
    logic                 rx_sat;
    logic [DATA_W-1:0]    rx_data;
    logic                 out_valid;
    logic                 out_sat;
    logic [DATA_W-1:0]    out_data;
  } ctsf_state_t;

  ctsf_state_t st;
  ctsf_state_t next_st;
  logic        rx_due;

  // Field-wise modulo add of an offset to a timer value
  function automatic ctsf_pkg::ctsf_ts_t ts_add(
    input ctsf_pkg::ctsf_ts_t a,
    input ctsf_pkg::ctsf_ts_t b
  );
    ctsf_pkg::ctsf_ts_t r;
    logic [12:0]        sub;
    logic [13:0]        cnt;
    logic               c_sub;
    logic               c_cnt;
    sub = {1'b0, a.sub_cycle_field} + {1'b0, b.sub_cycle_field};
    c_sub = (sub >= ctsf_pkg::SUB_CYCLE_MOD);
    if (c_sub)
    begin
      sub = sub - ctsf_pkg::SUB_CYCLE_MOD;
    end
    cnt = {1'b0, a.cycle_count_field} + {1'b0, b.cycle_count_field}
          + {13'h0000, c_sub};
    c_cnt = (cnt >= ctsf_pkg::CYCLE_CNT_MOD);
    if (c_cnt)
    begin
      cnt = cnt - ctsf_pkg::CYCLE_CNT_MOD;
    end
    r.sub_cycle_field      = sub[11:0];
    r.cycle_count_field    = cnt[12:0];
    // Seconds simply wrap at 128
    r.seconds_offset_field = a.seconds_offset_field
                             + b.seconds_offset_field
                             + {6'h00, c_cnt};
    return r;
  endfunction

  // Timer has reached a release time within the same cycle slot.
  // Equality on seconds and count avoids a full modular compare; the
  // timer must step through every cycle count, which it does whenever load is low.
  assign rx_due =
    (cycle_timer_reg.seconds_offset_field == st.rx_release.seconds_offset_field)
    && (cycle_timer_reg.cycle_count_field == st.rx_release.cycle_count_field)
    && (cycle_timer_reg.sub_cycle_field >= st.rx_release.sub_cycle_field);

  // Next-state logic: register port, stamping, receive hold
  always_comb
  begin
    next_st = st;
    next_st.tx_valid  = 1'b0;
    next_st.out_valid = 1'b0;
    next_st.rdata     = 32'h0000_0000;

    // Register writes; both aliases land in one store
    if (bus_req.wr)
    begin
      if (bus_req.addr == ctsf_pkg::OFS_TX_MPEG ||
          bus_req.addr == ctsf_pkg::OFS_TX_SAT)
      begin
        // All 32 bits stored as written; range kept by software
        next_st.tx_off = ctsf_pkg::ctsf_ts_t'(bus_req.wdata);
      end
      else if (bus_req.addr == ctsf_pkg::OFS_RX_MPEG ||
               bus_req.addr == ctsf_pkg::OFS_RX_SAT)
      begin
        next_st.rx_off = ctsf_pkg::ctsf_ts_t'(bus_req.wdata);
      end
      else if (bus_req.addr == ctsf_pkg::OFS_APP_CTL)
      begin
        // Bits 4 to 14 and 16 up are not stored
        next_st.ctl.iso_rx_fifo_en   = bus_req.wdata[ctsf_pkg::BIT_ISO_RX];
        next_st.ctl.iso_tx_fifo_en   = bus_req.wdata[ctsf_pkg::BIT_ISO_TX];
        next_st.ctl.async_rx_fifo_en = bus_req.wdata[ctsf_pkg::BIT_ASYNC_RX];
        next_st.ctl.async_tx_fifo_en = bus_req.wdata[ctsf_pkg::BIT_ASYNC_TX];
        next_st.ctl.iso_capture_all  =
          bus_req.wdata[ctsf_pkg::BIT_CAPTURE_ALL];
      end
    end

    // Bus reset wins over a software set in the same cycle
    if (link_bus_reset)
    begin
      next_st.ctl.async_tx_fifo_en = 1'b0;
    end

    // Register reads; unmapped addresses return zero
    if (bus_req.rd)
    begin
      if (bus_req.addr == ctsf_pkg::OFS_TX_MPEG ||
          bus_req.addr == ctsf_pkg::OFS_TX_SAT)
      begin
        next_st.rdata = st.tx_off;
      end
      else if (bus_req.addr == ctsf_pkg::OFS_RX_MPEG ||
               bus_req.addr == ctsf_pkg::OFS_RX_SAT)
      begin
        next_st.rdata = st.rx_off;
      end
      else if (bus_req.addr == ctsf_pkg::OFS_APP_CTL)
      begin
        next_st.rdata[ctsf_pkg::BIT_ISO_RX]      = st.ctl.iso_rx_fifo_en;
        next_st.rdata[ctsf_pkg::BIT_ISO_TX]      = st.ctl.iso_tx_fifo_en;
        next_st.rdata[ctsf_pkg::BIT_ASYNC_RX]    = st.ctl.async_rx_fifo_en;
        next_st.rdata[ctsf_pkg::BIT_ASYNC_TX]    = st.ctl.async_tx_fifo_en;
        next_st.rdata[ctsf_pkg::BIT_CAPTURE_ALL] = st.ctl.iso_capture_all;
      end
    end

    // Transmit stamp: same offset for both cell formats
    if (tx_cell_req)
    begin
      next_st.tx_stamp = ts_add(cycle_timer_reg, st.tx_off);
      next_st.tx_valid = 1'b1;
      next_st.tx_sat   = tx_cell_sat;
    end

    // Receive hold machine
    case (st.rx_st)
      ctsf_pkg::RX_IDLE:
      begin
        if (rx_cell_valid)
        begin
          next_st.rx_release = ts_add(rx_cell_stamp, st.rx_off);
          next_st.rx_sat     = rx_cell_sat;
          next_st.rx_data    = rx_cell_data;
          next_st.rx_st      = ctsf_pkg::RX_HOLD;
        end
      end
      ctsf_pkg::RX_HOLD:
      begin
        if (rx_due)
        begin
          next_st.out_valid = 1'b1;
          next_st.out_sat   = st.rx_sat;
          next_st.out_data  = st.rx_data;
          next_st.rx_st     = ctsf_pkg::RX_IDLE;
        end
      end
      default:
      begin
        next_st.rx_st = ctsf_pkg::RX_IDLE;
      end
    endcase

    // Software reset clears both offsets and the control register
    if (soft_rst)
    begin
      next_st.tx_off = ctsf_pkg::ctsf_ts_t'(ctsf_pkg::RST_OFFSET);
      next_st.rx_off = ctsf_pkg::ctsf_ts_t'(ctsf_pkg::RST_OFFSET);
      next_st.ctl    = ctsf_pkg::ctsf_ctl_t'(ctsf_pkg::RST_APP_CTL[4:0]);
    end
  end

  // State register
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st            <= '0;
      st.rx_st      <= ctsf_pkg::RX_IDLE;
    end
    else
    begin
      st <= next_st;
    end
  end

  // Outputs; all from the state register, rx_cell_ready decoded from the hold state
  assign bus_rdata      = st.rdata;
  assign tx_stamp_valid = st.tx_valid;
  assign tx_stamp_sat   = st.tx_sat;
  assign tx_stamp       = st.tx_stamp;
  assign rx_cell_ready  = (st.rx_st == ctsf_pkg::RX_IDLE);
  assign rx_app_valid   = st.out_valid;
  assign rx_app_sat     = st.out_sat;
  assign rx_app_data    = st.out_data;
  assign fifo_ctl       = st.ctl;

  // FIFO gating by the enables
  assign iso_rx_accept   = st.ctl.iso_rx_fifo_en && iso_pkt_valid
                           && (iso_chan_match || st.ctl.iso_capture_all);
  assign iso_tx_send     = st.ctl.iso_tx_fifo_en && iso_tx_pending;
  assign async_rx_accept = st.ctl.async_rx_fifo_en && async_pkt_valid;
  assign async_tx_send   = st.ctl.async_tx_fifo_en && async_tx_pending;

  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  chk_tx_alias_rw: assert property (
    (bus_req.wr && bus_req.addr == ctsf_pkg::OFS_TX_MPEG && !soft_rst)
    ##1 (bus_req.rd && bus_req.addr == ctsf_pkg::OFS_TX_SAT)
    |=> bus_rdata == $past(bus_req.wdata, 2))
    else $error("transmit offset alias mismatch");

  chk_rx_alias_rw: assert property (
    (bus_req.wr && bus_req.addr == ctsf_pkg::OFS_RX_SAT && !soft_rst)
    ##1 (bus_req.rd && bus_req.addr == ctsf_pkg::OFS_RX_MPEG)
    |=> bus_rdata == $past(bus_req.wdata, 2))
    else $error("receive offset alias mismatch");

  chk_tx_mpeg_stamp: assert property (
    tx_cell_req && !tx_cell_sat |=> tx_stamp_valid && !tx_stamp_sat
    && tx_stamp == ts_add($past(cycle_timer_reg), $past(st.tx_off)))
    else $error("MPEG transmit stamp wrong");

  chk_tx_sat_stamp: assert property (
    tx_cell_req && tx_cell_sat |=> tx_stamp_valid && tx_stamp_sat
    && tx_stamp == ts_add($past(cycle_timer_reg), $past(st.tx_off)))
    else $error("satellite transmit stamp wrong");

  chk_rx_release_calc: assert property (
    rx_cell_valid && rx_cell_ready |=> !rx_cell_ready
    && st.rx_release == ts_add($past(rx_cell_stamp), $past(st.rx_off)))
    else $error("receive release time wrong");

  chk_rx_hold_due: assert property (
    rx_app_valid |-> $past(rx_due) && !$past(rx_cell_ready)
    && rx_cell_ready)
    else $error("cell released before its time");

  chk_bus_reset_clr: assert property (
    link_bus_reset |=> !fifo_ctl.async_tx_fifo_en [*2]
    or (!fifo_ctl.async_tx_fifo_en ##1 $past(bus_req.wr)))
    else $error("bus reset left async transmit on");

  chk_soft_reset_clr: assert property (
    soft_rst |=> st.tx_off == '0 && st.rx_off == '0 && fifo_ctl == '0)
    else $error("software reset left bits set");

  chk_ctl_unused_zero: assert property (
    bus_req.rd && bus_req.addr == ctsf_pkg::OFS_APP_CTL
    |=> bus_rdata[14:4] == '0 && bus_rdata[31:16] == '0)
    else $error("unused control bits read nonzero");

  chk_iso_rx_gate: assert property (
    iso_rx_accept |-> fifo_ctl.iso_rx_fifo_en
    && (iso_chan_match || fifo_ctl.iso_capture_all))
    else $error("iso receive accepted while off");

  chk_fifo_send_gate: assert property (
    (iso_tx_send |-> fifo_ctl.iso_tx_fifo_en)
    and (async_rx_accept |-> fifo_ctl.async_rx_fifo_en)
    and (async_tx_send |-> fifo_ctl.async_tx_fifo_en))
    else $error("FIFO moved data while disabled");

  chk_stamp_range: assert property (
    tx_stamp_valid && $past(cycle_timer_reg.sub_cycle_field) < 12'hc00
    && $past(st.tx_off.sub_cycle_field) < 12'hc00
    |-> tx_stamp.sub_cycle_field < 12'hc00)
    else $error("sub-cycle carry not applied");

  cov_tx_stamp: cover property (tx_cell_req ##1 tx_stamp_valid);
  cov_rx_release: cover property (
    rx_cell_valid && rx_cell_ready ##[1:200] rx_app_valid);
  cov_bus_reset: cover property (
    fifo_ctl.async_tx_fifo_en && link_bus_reset);
  cov_alias_b2b: cover property (
    bus_req.wr ##1 bus_req.rd ##1 bus_rdata != '0);

endmodule

//--- bench/ctsf_timer_model.sv
// Cycle timer source standing in for the link's running timer
`timescale 1ns/1ps
module ctsf_timer_model (
  input  wire logic               ref_clk,
  input  wire logic               arst_n,
  input  wire logic               load,
  input  wire ctsf_pkg::ctsf_ts_t load_val,
  output ctsf_pkg::ctsf_ts_t      timer
);
  logic sub_wrap;
  logic cnt_wrap;

  // Wrap points of the two lower fields
  assign sub_wrap = (timer.sub_cycle_field == 12'h0bff);
  assign cnt_wrap = (timer.cycle_count_field == 13'h1f3f);

  // Ticks once a clock, far faster than a real timer, to keep runs short
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      timer <= '0;
    else if (load)
      timer <= load_val;
    else
    begin
      timer.sub_cycle_field <= sub_wrap ? 12'h000 : timer.sub_cycle_field + 12'h001;
      if (sub_wrap)
        timer.cycle_count_field <= cnt_wrap ? 13'h0000 : timer.cycle_count_field + 13'h0001;
      if (sub_wrap && cnt_wrap)
        timer.seconds_offset_field <= timer.seconds_offset_field + 7'h01;
    end
  end
endmodule

//--- bench/testbench.sv
// Self-checking bench for the timestamp offset and FIFO control bank
`timescale 1ns/1ps
module testbench;
  localparam int SUBM = int'(ctsf_pkg::SUB_CYCLE_MOD);
  localparam int CNTM = int'(ctsf_pkg::CYCLE_CNT_MOD);
  logic ref_clk = 1'b0, arst_n = 1'b0, soft_rst = 1'b0, link_bus_reset = 1'b0;
  ctsf_pkg::ctsf_bus_req_t bus_req = '0;
  logic [31:0] bus_rdata, app_data, rx_data = '0;
  ctsf_pkg::ctsf_ts_t timer, tx_stamp, load_val = '0, rx_stamp = '0;
  logic tload = 1'b1, tx_req = 1'b0, tx_sat = 1'b0, rx_valid = 1'b0;
  logic rx_sat = 1'b0, tx_valid, tx_sat_o, rx_ready, app_valid, app_sat;
  logic [4:0] pk = '0;
  logic iso_acc, iso_send, arx_acc, atx_send;
  ctsf_pkg::ctsf_ctl_t fifo_ctl;
  int mismatches = 0;
  int cmp_count = 0;
  int seed = 32'h907f_a6bf;

  // Free-running reference clock
  always #20 ref_clk = ~ref_clk;

  ctsf_regs ctsf_regs_i (
    .ref_clk(ref_clk), .arst_n(arst_n), .soft_rst(soft_rst),
    .link_bus_reset(link_bus_reset), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .cycle_timer_reg(timer), .tx_cell_req(tx_req),
    .tx_cell_sat(tx_sat), .tx_stamp_valid(tx_valid),
    .tx_stamp_sat(tx_sat_o), .tx_stamp(tx_stamp),
    .rx_cell_valid(rx_valid), .rx_cell_ready(rx_ready),
    .rx_cell_sat(rx_sat), .rx_cell_stamp(rx_stamp),
    .rx_cell_data(rx_data), .rx_app_valid(app_valid),
    .rx_app_sat(app_sat), .rx_app_data(app_data),
    .iso_pkt_valid(pk[0]), .iso_chan_match(pk[1]), .iso_rx_accept(iso_acc),
    .iso_tx_pending(pk[2]), .iso_tx_send(iso_send),
    .async_pkt_valid(pk[3]), .async_rx_accept(arx_acc),
    .async_tx_pending(pk[4]), .async_tx_send(atx_send), .fifo_ctl(fifo_ctl)
  );

  ctsf_timer_model ctsf_timer_model_i (
    .ref_clk(ref_clk), .arst_n(arst_n), .load(tload),
    .load_val(load_val), .timer(timer)
  );

  // Single comparison point; unknowns never match
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One-cycle write strobe, released at the next edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    bus_req <= {1'b0, 1'b1, a, d};
    @(posedge ref_clk);
    bus_req <= '0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rchk(input string what, input logic [7:0] a,
                      input logic [31:0] exp);
    @(posedge ref_clk);
    bus_req <= {1'b1, 1'b0, a, 32'h0000_0000};
    @(posedge ref_clk);
    bus_req <= '0;
    #1;
    check(what, bus_rdata, exp);
  endtask

  // Write then read back with no idle cycle between the two strobes
  task automatic wrrd(input string what, input logic [7:0] a0,
                      input logic [7:0] a1, input logic swap,
                      input logic [31:0] d);
    @(posedge ref_clk);
    bus_req <= {1'b0, 1'b1, swap ? a1 : a0, d};
    @(posedge ref_clk);
    bus_req <= {1'b1, 1'b0, swap ? a0 : a1, 32'h0000_0000};
    @(posedge ref_clk);
    bus_req <= '0;
    #1;
    check(what, bus_rdata, d);
  endtask

  task automatic conclude;
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Random timer word, kept inside the software maxima
  function automatic ctsf_pkg::ctsf_ts_t rts();
    ctsf_pkg::ctsf_ts_t r;
    r.sub_cycle_field = 12'($unsigned($random(seed)) % SUBM);
    r.cycle_count_field = 13'($unsigned($random(seed)) % CNTM);
    r.seconds_offset_field = 7'($random(seed));
    return r;
  endfunction

  // Field-wise modular sum with carries between fields
  function automatic ctsf_pkg::ctsf_ts_t tadd(ctsf_pkg::ctsf_ts_t a,
                                              ctsf_pkg::ctsf_ts_t b);
    int s, c, e;
    s = a.sub_cycle_field + b.sub_cycle_field;
    c = a.cycle_count_field + b.cycle_count_field + (s >= SUBM);
    e = a.seconds_offset_field + b.seconds_offset_field + (c >= CNTM);
    if (s >= SUBM) s -= SUBM;
    if (c >= CNTM) c -= CNTM;
    return {12'(s), 13'(c), 7'(e)};
  endfunction

  // Main sequence
  initial
  begin
    logic [31:0] w;
    ctsf_pkg::ctsf_ts_t t, off, rel;
    int n;
    repeat (6) @(posedge ref_clk);
    arst_n <= 1'b1;
    rchk("tx off rst", ctsf_pkg::OFS_TX_MPEG, 32'h0000_0000);
    rchk("rx off rst", ctsf_pkg::OFS_RX_SAT, 32'h0000_0000);
    rchk("ctl rst", ctsf_pkg::OFS_APP_CTL, 32'h0000_0000);
    rchk("unmapped", 8'hf0, 32'h0000_0000);
    // Aliased stores, crossing addresses; first transmit pass at the field maxima
    for (int i = 0; i < 8; i++)
    begin
      t = (i == 0) ? {12'hbff, 13'h1f3f, 7'h7f} : rts();
      off = rts();
      wrrd("tx alias", ctsf_pkg::OFS_TX_SAT, ctsf_pkg::OFS_TX_MPEG, i[0], t);
      wrrd("rx alias", ctsf_pkg::OFS_RX_MPEG, ctsf_pkg::OFS_RX_SAT, i[0], off);
    end
    // Control bits against random FIFO traffic
    for (int i = 0; i < 16; i++)
    begin
      w = (i == 0) ? 32'hffff_ffff : $random(seed);
      wr(ctsf_pkg::OFS_APP_CTL, w);
      pk <= 5'($random(seed));
      rchk("ctl", ctsf_pkg::OFS_APP_CTL, w & 32'h0000_800f);
      check("fifo_ctl", 32'(fifo_ctl), {w[15], w[3:0]});
      check("iso rx", iso_acc, pk[0] & w[0] & (pk[1] | w[15]));
      check("iso tx", iso_send, pk[2] & w[1]);
      check("async rx", arx_acc, pk[3] & w[2]);
      check("async tx", atx_send, pk[4] & w[3]);
    end
    // Serial bus reset drops only the async transmit enable
    // A write that sets the enable in the reset cycle still loses
    wr(ctsf_pkg::OFS_APP_CTL, 32'h0000_800f);
    @(posedge ref_clk);
    link_bus_reset <= 1'b1;
    bus_req <= {1'b0, 1'b1, ctsf_pkg::OFS_APP_CTL, 32'h0000_800f};
    @(posedge ref_clk);
    link_bus_reset <= 1'b0;
    bus_req <= '0;
    rchk("bus reset", ctsf_pkg::OFS_APP_CTL, 32'h0000_8007);
    // Transmit stamps with a frozen timer; first pass carries every field
    for (int i = 0; i < 8; i++)
    begin
      off = (i == 0) ? {12'hbff, 13'h1f3f, 7'h7f} : rts();
      t = (i == 0) ? off : rts();
      wr(i[0] ? ctsf_pkg::OFS_TX_SAT : ctsf_pkg::OFS_TX_MPEG, off);
      load_val <= t;
      @(posedge ref_clk);
      tx_req <= 1'b1;
      tx_sat <= i[1];
      @(posedge ref_clk);
      tx_req <= 1'b0;
      #1;
      check("tx valid", tx_valid, 1'b1);
      check("tx stamp", tx_stamp, tadd(t, off));
      check("tx sat", tx_sat_o, i[1]);
    end
    // Received cells held until the timer reaches stamp plus offset
    for (int i = 0; i < 4; i++)
    begin
      off = rts();
      off.sub_cycle_field = 12'(3 + $unsigned($random(seed)) % 1000);
      t = rts();
      t.sub_cycle_field = 12'($unsigned($random(seed)) % 2000);
      rel = tadd(t, off);
      wr(i[0] ? ctsf_pkg::OFS_RX_SAT : ctsf_pkg::OFS_RX_MPEG, off);
      tload <= 1'b1;
      load_val <= {rel.sub_cycle_field - 12'h003, rel[19:0]};
      rx_valid <= 1'b1;
      rx_stamp <= t;
      rx_sat <= i[1];
      rx_data <= $random(seed);
      @(posedge ref_clk);
      rx_valid <= 1'b0;
      #1;
      check("rx held", rx_ready, 1'b0);
      @(posedge ref_clk);
      tload <= 1'b0;
      n = 0;
      while (app_valid !== 1'b1 && n < 40)
      begin
        @(posedge ref_clk);
        #1;
        n++;
      end
      // A lost release adds one mismatch on top of the delay check; the run goes on to the verdict
      if (n >= 40)
        mismatches++;
      check("release delay", n, 4);
      check("rx data", app_data, rx_data);
      check("rx sat", app_sat, i[1]);
      check("rx ready again", rx_ready, 1'b1);
    end
    // Software reset clears offsets and control
    wr(ctsf_pkg::OFS_TX_SAT, 32'h1234_5678);
    wr(ctsf_pkg::OFS_APP_CTL, 32'h0000_800f);
    @(posedge ref_clk);
    soft_rst <= 1'b1;
    @(posedge ref_clk);
    soft_rst <= 1'b0;
    rchk("soft tx", ctsf_pkg::OFS_TX_MPEG, 32'h0000_0000);
    rchk("soft rx", ctsf_pkg::OFS_RX_MPEG, 32'h0000_0000);
    rchk("soft ctl", ctsf_pkg::OFS_APP_CTL, 32'h0000_0000);
    conclude();
  end
endmodule
